// ==== rtl/afs_dc_if.sv ====
`timescale 1ns/1ns
interface afs_dc_if;
    logic over;
    logic pol;
    logic clear;
    logic trip;
    modport mon (input over, input pol, input clear, output trip);
    modport ctl (output over, output pol, output clear, input trip);
endinterface

// ==== rtl/afs_dc_timer.sv ====
`timescale 1ns/1ns
`include "afs_map.svh"
module afs_dc_timer #(
    parameter int unsigned QUAL_CYC = `AFS_DC_QUAL_CYC
) (
    input wire logic core_clk, // Core clock
    input wire logic arst_n, // Async reset
    afs_dc_if.mon dc // Duty monitor link
);
    import afs_pkg::*;
    afs_dc_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (!dc.over || (s_q.active && dc.pol != s_q.pol)) begin
            s_d.active = dc.over; // RULE13
            s_d.pol = dc.pol;
            s_d.cnt = '0;
        end else if (!s_q.active) begin
            s_d.active = 1'b1;
            s_d.pol = dc.pol;
            s_d.cnt = '0;
        end else if (s_q.cnt >= QUAL_CYC - 1) begin
            s_d.trip = 1'b1; // RULE6
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
        // Clear wins over a trip in the same cycle, so auto recovery always drops the latch
        if (dc.clear) begin
            s_d.active = 1'b0;
            s_d.cnt = '0;
            s_d.trip = 1'b0; // RULE7
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dc.trip = s_q.trip;
endmodule // afs_dc_timer

// ==== rtl/afs_map.svh ====
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH
// Function
// (RULE1) Shutdown input low mutes outputs and enters low-current state; high amplifies.
// (RULE2) Gain selection captured once at end of start-up, held until power-up.
// (RULE3) Start-up cycle lasts about 10 ms before amplification begins.
// (RULE4) Over-current, over-temperature, DC-offset faults latch, assert fault, outputs high-Z.
// (RULE5) Supply under/over-voltage forces high-Z without fault; self-clears when in range.
// (RULE6) DC fault when either channel's duty exceeds limit, same polarity, past 420 ms.
// (RULE7) Shutdown low clears DC latch; fault wired to shutdown auto-recovers.
// (RULE8) Over-current latch cleared by shutdown low; outputs stay high-Z until then.
// (RULE9) Power limiter caps duty at fixed maximum; virtual rail about four times limit.
// (RULE10) Controller holds shutdown low at power-up until inputs are stable.
// (RULE11) Controller enters shutdown before removing power.
// (RULE12) Controller always drives shutdown to a defined level, never floating.
// (RULE13) DC timer restarts when duty returns in range or polarity changes.

`define AFS_CLK_MHZ 125
`define AFS_STARTUP_MS 10
`define AFS_STARTUP_CYC (`AFS_STARTUP_MS * 1000 * `AFS_CLK_MHZ)
`define AFS_DC_QUAL_MS 420
`define AFS_DC_QUAL_CYC (`AFS_DC_QUAL_MS * 1000 * `AFS_CLK_MHZ)
`define AFS_DUTY_LIMIT_PCT 60
`define AFS_RAIL_FACTOR 4
`define AFS_GAIN_RESET 3'h0
`define AFS_POL_POS 1'b1
`define AFS_POL_NEG 1'b0
`endif

// ==== rtl/afs_pkg.sv ====
package afs_pkg;
    typedef enum logic [1:0] {
        AFS_ST_STARTUP = 2'b00,
        AFS_ST_SHUTDOWN = 2'b01,
        AFS_ST_RUN = 2'b10,
        AFS_ST_FAULT = 2'b11
    } afs_state_type;

    typedef struct packed {
        logic [31:0] cnt;
        logic active;
        logic pol;
        logic trip;
    } afs_dc_type;
endpackage

// ==== rtl/afs_supervisor.sv ====
`timescale 1ns/1ns
`include "afs_map.svh"
module afs_supervisor #(
    parameter int unsigned STARTUP_CYC = `AFS_STARTUP_CYC,
    parameter int unsigned DC_QUAL_CYC = `AFS_DC_QUAL_CYC,
    parameter int unsigned DUTY_W = 8
) (
    input wire logic core_clk, // Core clock, 125 MHz
    input wire logic arst_n, // Power-up reset
    input wire logic shutdown_n_input, // Shutdown, active low
    input wire logic [2:0] gain_role_select, // Gain/role code from divider
    input wire logic over_current, // Output short detected
    input wire logic over_temp, // Die over temperature
    input wire logic supply_under, // Stage supply below limit
    input wire logic supply_over, // Stage supply above limit
    input wire logic [DUTY_W-1:0] duty_left, // Left diff duty, full scale 100%
    input wire logic pol_left, // Left polarity, 1 positive
    input wire logic [DUTY_W-1:0] duty_right, // Right diff duty
    input wire logic pol_right, // Right polarity
    input wire logic [DUTY_W-1:0] duty_request, // Modulator duty demand
    input wire logic [DUTY_W-1:0] power_limit_level, // Duty cap from limit pin
    output logic fault_n_output, // Latched fault, active low
    output logic outputs_hiz, // Bridge outputs high impedance
    output logic outputs_mute, // Mute request
    output logic low_power, // Low-current state
    output logic amp_enable, // Amplifying
    output logic [2:0] gain_latched, // Captured gain code
    output logic [DUTY_W-1:0] duty_out // Limited duty demand
);
    import afs_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        afs_state_type st;
        logic [31:0] cnt;
        logic oc;
        logic ot;
        logic fault_n;
        logic hiz;
        logic mute;
        logic lowp;
        logic en;
        logic [2:0] gain;
        logic [DUTY_W-1:0] duty;
    } afs_top_type;

    afs_top_type s_q, s_d;
    afs_dc_if dcl();
    afs_dc_if dcr();

    function automatic logic over_lim(input logic [DUTY_W-1:0] d);
        // Compare duty*100 against limit*full scale
        logic [DUTY_W+7:0] lhs;
        logic [DUTY_W+7:0] rhs;
        lhs = (DUTY_W+8)'(d) * (DUTY_W+8)'(100);
        rhs = (DUTY_W+8)'(`AFS_DUTY_LIMIT_PCT) * (DUTY_W+8)'({DUTY_W{1'b1}});
        return lhs > rhs;
    endfunction

    // ----------------------------------------
    // DC monitors
    // ----------------------------------------
    assign dcl.over = over_lim(duty_left); // RULE6
    assign dcl.pol = pol_left;
    assign dcl.clear = !shutdown_n_input; // RULE7
    assign dcr.over = over_lim(duty_right); // RULE6
    assign dcr.pol = pol_right;
    assign dcr.clear = !shutdown_n_input; // RULE7

    afs_dc_timer #(.QUAL_CYC(DC_QUAL_CYC)) u_dc_l (.core_clk(core_clk), .arst_n(arst_n), .dc(dcl));
    afs_dc_timer #(.QUAL_CYC(DC_QUAL_CYC)) u_dc_r (.core_clk(core_clk), .arst_n(arst_n), .dc(dcr));

    // ----------------------------------------
    // Control
    // ----------------------------------------
    always_comb begin
        logic latched;
        logic supply_bad;
        latched = 1'b0;
        supply_bad = supply_under || supply_over;
        s_d = s_q;
        // Over-current and over-temperature sets beat the shutdown clear so no event is dropped
        if (!shutdown_n_input) begin
            s_d.oc = 1'b0; // RULE8
            s_d.ot = 1'b0;
        end
        if (over_current) begin
            s_d.oc = 1'b1; // RULE4
        end
        if (over_temp) begin
            s_d.ot = 1'b1; // RULE4
        end
        latched = s_d.oc || s_d.ot || dcl.trip || dcr.trip;
        unique case (s_q.st)
            AFS_ST_STARTUP: begin
                if (s_q.cnt >= STARTUP_CYC - 1) begin
                    s_d.gain = gain_role_select; // RULE2
                    s_d.st = AFS_ST_SHUTDOWN; // RULE3
                end else begin
                    s_d.cnt = s_q.cnt + 32'h0000_0001;
                end
            end
            AFS_ST_SHUTDOWN: begin
                if (shutdown_n_input) begin
                    s_d.st = AFS_ST_RUN;
                end
            end
            AFS_ST_RUN: begin
                if (!shutdown_n_input) begin
                    s_d.st = AFS_ST_SHUTDOWN; // RULE1
                end else if (latched) begin
                    s_d.st = AFS_ST_FAULT;
                end
            end
            AFS_ST_FAULT: begin
                if (!shutdown_n_input) begin
                    s_d.st = AFS_ST_SHUTDOWN; // RULE8
                end
            end
        endcase
        if (s_q.st != AFS_ST_STARTUP && latched) begin
            s_d.st = AFS_ST_FAULT;
            if (!shutdown_n_input && !s_d.oc && !s_d.ot) begin
                s_d.st = AFS_ST_SHUTDOWN;
            end
        end
        s_d.fault_n = !latched; // RULE4
        s_d.mute = (s_d.st != AFS_ST_RUN); // RULE1
        s_d.lowp = (s_d.st == AFS_ST_SHUTDOWN); // RULE1
        // Supply out of range never touches the fault line
        s_d.hiz = (s_d.st != AFS_ST_RUN) || supply_bad; // RULE5
        s_d.en = (s_d.st == AFS_ST_RUN) && !supply_bad; // RULE5
        // Cap is a duty ceiling; the analog rail scales by AFS_RAIL_FACTOR
        s_d.duty = s_d.en ? ((duty_request > power_limit_level) ? power_limit_level : duty_request) : '0; // RULE9
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.st <= AFS_ST_STARTUP;
            s_q.gain <= `AFS_GAIN_RESET;
            s_q.fault_n <= 1'b1;
            s_q.hiz <= 1'b1;
            s_q.mute <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign fault_n_output = s_q.fault_n;
    assign outputs_hiz = s_q.hiz;
    assign outputs_mute = s_q.mute;
    assign low_power = s_q.lowp;
    assign amp_enable = s_q.en;
    assign gain_latched = s_q.gain;
    assign duty_out = s_q.duty;
endmodule // afs_supervisor

// ==== testbench/afs_ctl_model.sv ====
`timescale 1ns/1ns
module afs_ctl_model (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Power-up
    input wire logic run_req, // Sound wanted
    input wire logic auto_rec, // Fault strapped to shutdown
    input wire logic fault_n_output, // Fault line
    output logic shutdown_n_input // Shutdown, always driven
);
    // ----------------------------------------
    // Held low from power-up until the bench asks for sound
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) shutdown_n_input <= 1'b0;
        else shutdown_n_input <= run_req && !(auto_rec && !fault_n_output);
    end
endmodule // afs_ctl_model

// ==== testbench/afs_sup_props.sv ====
`timescale 1ns/1ns
module afs_sup_props #(
    parameter int unsigned STARTUP_CYC = 20,
    parameter int unsigned DUTY_W = 8
) (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic shutdown_n_input, // Shutdown
    input wire logic over_current, // Short
    input wire logic over_temp, // Hot
    input wire logic supply_under, // Low supply
    input wire logic supply_over, // High supply
    input wire logic [DUTY_W-1:0] duty_request, // Demand
    input wire logic [DUTY_W-1:0] power_limit_level, // Cap
    input wire logic fault_n_output, // Fault
    input wire logic outputs_hiz, // High-Z
    input wire logic outputs_mute, // Mute
    input wire logic low_power, // Low current
    input wire logic amp_enable, // Running
    input wire logic [2:0] gain_latched, // Gain
    input wire logic [DUTY_W-1:0] duty_out // Duty
);
    // ----------------------------------------
    // Saturating age count, so long runs never wrap
    // ----------------------------------------
    int unsigned up_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) up_q <= 0;
        else if (up_q < STARTUP_CYC) up_q <= up_q + 1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_oc; amp_enable && (over_current || over_temp) |=> !fault_n_output && outputs_hiz && !amp_enable;
    endproperty
    a_oc: assert property (p_oc) else $error("latched fault missed");
    property p_sup; amp_enable && (supply_under || supply_over) |=> outputs_hiz && !amp_enable; endproperty
    a_sup: assert property (p_sup) else $error("bad supply not high-Z");
    property p_hold; !fault_n_output && shutdown_n_input |=> outputs_hiz; endproperty
    a_hold: assert property (p_hold) else $error("outputs left high-Z early");
    property p_clr; (!shutdown_n_input && !over_current && !over_temp) [*2] |=> fault_n_output; endproperty
    a_clr: assert property (p_clr) else $error("shutdown did not clear");
    property p_sd; !shutdown_n_input && amp_enable && fault_n_output |-> ##[1:2] (outputs_mute && low_power);
    endproperty
    a_sd: assert property (p_sd) else $error("shutdown not honoured");
    property p_excl; amp_enable |-> !outputs_hiz && !outputs_mute && !low_power; endproperty
    a_excl: assert property (p_excl) else $error("run state mixed");
    property p_gain; low_power || amp_enable |=> $stable(gain_latched); endproperty
    a_gain: assert property (p_gain) else $error("gain moved");
    property p_start; low_power || amp_enable |-> up_q >= STARTUP_CYC; endproperty
    a_start: assert property (p_start) else $error("start-up too short");
    property p_cap; duty_out != 0 |-> duty_out == (($past(duty_request) < $past(power_limit_level)) ?
        $past(duty_request) : $past(power_limit_level)); endproperty
    a_cap: assert property (p_cap) else $error("duty not capped");
    c_fault: cover property ($fell(fault_n_output));
    c_run: cover property ($rose(amp_enable));
    c_sup: cover property (outputs_hiz && fault_n_output && supply_under);
endmodule // afs_sup_props
bind afs_supervisor afs_sup_props #(.STARTUP_CYC(STARTUP_CYC), .DUTY_W(DUTY_W)) u_props (.*);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t %h %h", $time, (a), (b)); end end
module tb_top;
    logic core_clk, arst_n, run_req, auto_rec, shutdown_n_input, over_current, over_temp, supply_under;
    logic supply_over, pol_left, pol_right, fault_n_output, outputs_hiz, outputs_mute, low_power, amp_enable;
    logic [2:0] gain_role_select, gain_latched;
    logic [7:0] duty_left, duty_right, duty_request, power_limit_level, duty_out;
    int bad_count = 0;
    int compares = 0;
    afs_supervisor #(.STARTUP_CYC(20), .DC_QUAL_CYC(30)) dut (.*);
    afs_ctl_model u_ctl (.*);
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task cyc(input int n); repeat (n) @(negedge core_clk); endtask
    task finish_test;
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wait_amp;
        for (int i = 0; i < 60 && amp_enable !== 1'b1; i++) cyc(1);
        if (amp_enable !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_start;
        cyc(10); `CHK(amp_enable | low_power, 1'b0);
        cyc(20); `CHK(low_power, 1'b1);
        `CHK(gain_latched, 3'h5);
    endtask
    task t_run;
        @(posedge core_clk); run_req <= 1; gain_role_select <= 3'h2; duty_request <= 8'hc8; power_limit_level <= 8'h64;
        wait_amp(); cyc(2); `CHK(duty_out, 8'h64);
        `CHK(gain_latched, 3'h5);
        @(posedge core_clk); duty_request <= 8'h32;
        cyc(2); `CHK(duty_out, 8'h32);
    endtask
    task t_latch(input int k);
        @(posedge core_clk); over_current <= (k == 0); over_temp <= (k == 1);
        @(posedge core_clk); over_current <= 0; over_temp <= 0;
        cyc(3); `CHK(fault_n_output, 1'b0);
        `CHK(outputs_hiz, 1'b1);
        @(posedge core_clk); run_req <= 0;
        cyc(4); `CHK(fault_n_output, 1'b1);
        `CHK(low_power, 1'b1);
        @(posedge core_clk); run_req <= 1;
        wait_amp();
    endtask
    task t_supply(input int k);
        @(posedge core_clk); supply_under <= (k == 0); supply_over <= (k == 1);
        cyc(3); `CHK(outputs_hiz, 1'b1);
        `CHK(fault_n_output, 1'b1);
        @(posedge core_clk); supply_under <= 0; supply_over <= 0;
        wait_amp(); `CHK(outputs_hiz, 1'b0);
    endtask
    task t_dc;
        @(posedge core_clk); duty_left <= 8'h9a; pol_left <= 1;
        cyc(20); @(posedge core_clk); pol_left <= 0;
        cyc(20); `CHK(fault_n_output, 1'b1);
        cyc(15); `CHK(fault_n_output, 1'b0);
        @(posedge core_clk); duty_left <= 0; auto_rec <= 1;
        wait_amp(); `CHK(fault_n_output, 1'b1);
    endtask
    task t_dc_right;
        int n;
        @(posedge core_clk); duty_right <= 8'hff; pol_right <= 0;
        for (n = 0; n < 60 && fault_n_output !== 1'b0; n++) cyc(1);
        // Qualification of 30 cycles plus one, then timer and supervisor registers
        `CHK(n, 30 + 3);
        if (fault_n_output !== 1'b0) finish_test();
        @(posedge core_clk); duty_right <= 0;
        wait_amp(); `CHK(fault_n_output, 1'b1);
    endtask
    task t_repower;
        @(posedge core_clk); run_req <= 0;
        cyc(4); `CHK(low_power, 1'b1);
        @(posedge core_clk); arst_n <= 0; gain_role_select <= 3'h3;
        cyc(4); `CHK(outputs_hiz, 1'b1);
        `CHK(fault_n_output, 1'b1);
        @(posedge core_clk); arst_n <= 1;
        cyc(30); `CHK(gain_latched, 3'h3);
        `CHK(low_power, 1'b1);
    endtask
    initial begin
        arst_n = 0; run_req = 0; auto_rec = 0; over_current = 0; over_temp = 0; supply_under = 0; supply_over = 0;
        pol_left = 1; pol_right = 1; gain_role_select = 3'h5; duty_left = 0; duty_right = 0;
        duty_request = 0; power_limit_level = 0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1;
        t_start();
        t_run();
        for (int k = 0; k < 2; k++) begin
            t_latch(k);
            t_supply(k);
        end
        t_dc();
        t_dc_right();
        t_repower();
        finish_test();
    end
endmodule // tb_top
